// File: rtl/hjb_exec.sv
// Execution unit for barrier jump register and byte loads.
// Assumes register reads, translation and memory replies come from the core.
//
// Contract
// - Barrier clears hazards before target fetch
// - Barrier jump accepted in every mode
// - Instruction bit 10 selects barrier form
// - Compressed ISA: select from bit0, clear bit0
// - No compressed ISA: low bits nonzero fault
// - Compressed ISA: bit0 zero bit1 one faults
// - Delay slot hazards stay uncleared
// - Execution barrier clears execution hazards only
// - Signed byte load sign-extends fetched byte
// - Unsigned byte load zero-extends fetched byte
// - Lane is address xor big order
// - Plain loads: no alignment, four exceptions
// - User space loads use 9-bit offset
// - User space loads reach three user segments
// - User space loads need addressing present bit
// - User space loads need control access enabled
// - User space loads report seven exception kinds
// - Delay slot executes before transfer
`timescale 1ns/1ps
module hjb_exec (
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    // Instruction issue
    input  wire logic        instr_valid_in,
    input  wire logic [31:0] instr_in,
    input  wire logic [31:0] src_reg_val_in,
    input  wire logic        slot_done_in,
    input  wire logic        execution_barrier_in,
    // Configuration and mode
    input  wire logic        compressed_isa_present_in,
    input  wire logic        extended_virtual_addressing_present_in,
    input  wire logic        control_access_en_in,
    input  wire logic        kernel_mode_in,
    input  wire logic        big_order_cpu_flag_in,
    input  wire logic        reverse_byte_order_flag_in,
    // Translation
    input  wire logic        xlate_done_in,
    input  wire logic [31:0] xlate_paddr_in,
    input  wire logic [2:0]  xlate_seg_mode_in,
    input  wire logic        xlate_refill_in,
    input  wire logic        xlate_invalid_in,
    input  wire logic        xlate_addr_err_in,
    input  wire logic        xlate_watch_in,
    // Memory
    input  wire logic        mem_done_in,
    input  wire logic [31:0] mem_word_in,
    input  wire logic        mem_bus_err_in,
    // Fetch side alignment check
    input  wire logic        fetch_target_in,
    // Results
    output logic             busy_out,
    output logic             xlate_req_out,
    output logic [31:0]      xlate_vaddr_out,
    output logic             xlate_user_map_out,
    output logic             mem_req_out,
    output logic [31:0]      mem_paddr_out,
    output logic             wb_valid_out,
    output logic [4:0]       wb_reg_out,
    output logic [31:0]      wb_data_out,
    output logic             pc_load_out,
    output logic [31:0]      pc_out,
    output logic             instruction_set_select_out,
    output logic             exec_hazard_clear_out,
    output logic             instr_hazard_clear_out,
    output logic             exc_valid_out,
    output logic [3:0]       exc_code_out
);
    import hjb_pkg::*;

    typedef struct packed {
        hjb_state_type st;
        logic          is_signed;
        logic          user_sp;
        logic [4:0]    tgt;
        logic [31:0]   vaddr;
        logic [31:0]   jtarget;
        logic          jbarrier;
        logic          target_misalign;
        logic          busy;
        logic          xreq;
        logic          xuser;
        logic          mreq;
        logic [31:0]   paddr;
        logic          wb_v;
        logic [4:0]    wb_r;
        logic [31:0]   wb_d;
        logic          pc_ld;
        logic [31:0]   pc;
        logic          isa_sel;
        logic          ehz;
        logic          ihz;
        logic          exc_v;
        logic [3:0]    exc_c;
    } hjb_regs_type;

    hjb_regs_type cur_ff;
    hjb_regs_type nxt_ff;

    logic [31:0] lane_value;

    // Sign extended offset helpers
    function automatic logic [31:0] sext16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction
    function automatic logic [31:0] sext9(input logic [8:0] v);
        return {{23{v[8]}}, v};
    endfunction
    // Target alignment fault depends on compressed ISA presence
    function automatic logic target_fault(input logic [31:0] t, input logic ca);
        return ca ? (~t[0] & t[1])
                  : (t[1:0] != 2'h0);
    endfunction

    // Decode of the issued word
    logic [5:0] op;
    logic [5:0] fn;
    logic       dec_jr;
    logic       dec_lb;
    logic       dec_lbu;
    logic       dec_lbe;
    logic       dec_load_unsigned_byte_user_space;
    always_comb begin
        op       = instr_in[31:POS_OP];
        fn       = instr_in[5:0];
        dec_jr   = (op == OP_REGULAR) && (fn == FN_JUMP_REG) && (instr_in[20:11] == 10'h000);
        dec_lb   = (op == OP_LD_SBYTE);
        dec_lbu  = (op == OP_LD_UBYTE);
        dec_lbe  = (op == OP_EXT_GROUP) && (fn == FN_LD_SBYTE_U) && !instr_in[6];
        dec_load_unsigned_byte_user_space = (op == OP_EXT_GROUP) && (fn == FN_LD_UBYTE_U) && !instr_in[6];
    end

    hjb_lane_extract u_lane (
        .word_in               (mem_word_in),
        .vaddr_lo_in           (cur_ff.vaddr[1:0]),
        .big_order_cpu_flag_in (big_order_cpu_flag_in),
        .signed_in             (cur_ff.is_signed),
        .value_out             (lane_value)
    );

    // Next state logic
    always_comb begin
        nxt_ff       = cur_ff;
        nxt_ff.wb_v  = 1'b0;
        nxt_ff.pc_ld = 1'b0;
        nxt_ff.ehz   = 1'b0;
        nxt_ff.ihz   = 1'b0;
        nxt_ff.exc_v = 1'b0;
        nxt_ff.exc_c = EXC_NONE;
        // Execution barrier clears only execution hazards
        if (execution_barrier_in) begin
            nxt_ff.ehz = 1'b1;
        end
        // Alignment fault raised only when the target is fetched
        if (fetch_target_in && cur_ff.target_misalign) begin
            nxt_ff.exc_v           = 1'b1;
            nxt_ff.exc_c           = EXC_ADDR;
            nxt_ff.target_misalign = 1'b0;
        end
        unique case (cur_ff.st)
            ST_IDLE: begin
                if (instr_valid_in && dec_jr) begin
                    // Accepted regardless of mode or access enable
                    nxt_ff.jbarrier = instr_in[POS_BARRIER];
                    nxt_ff.jtarget  = src_reg_val_in;
                    nxt_ff.st       = ST_SLOT;
                    nxt_ff.busy     = 1'b1;
                end else if (instr_valid_in && (dec_lb || dec_lbu)) begin
                    nxt_ff.vaddr     = sext16(instr_in[15:0]) + src_reg_val_in;
                    nxt_ff.is_signed = dec_lb;
                    nxt_ff.user_sp   = 1'b0;
                    nxt_ff.tgt       = instr_in[20:POS_TGT];
                    nxt_ff.xreq      = 1'b1;
                    nxt_ff.xuser     = 1'b0;
                    nxt_ff.st        = ST_XLATE;
                    nxt_ff.busy      = 1'b1;
                end else if (instr_valid_in && (dec_lbe || dec_load_unsigned_byte_user_space)) begin
                    if (!extended_virtual_addressing_present_in) begin
                        nxt_ff.exc_v = 1'b1;
                        nxt_ff.exc_c = EXC_RESV_INS;
                    end else if (!control_access_en_in) begin
                        nxt_ff.exc_v = 1'b1;
                        nxt_ff.exc_c = EXC_COP_UNUSE;
                    end else begin
                        nxt_ff.vaddr     = sext9(instr_in[15:POS_OFF9]) + src_reg_val_in;
                        nxt_ff.is_signed = dec_lbe;
                        nxt_ff.user_sp   = 1'b1;
                        nxt_ff.tgt       = instr_in[20:POS_TGT];
                        nxt_ff.xreq      = 1'b1;
                        nxt_ff.xuser     = kernel_mode_in;
                        nxt_ff.st        = ST_XLATE;
                        nxt_ff.busy      = 1'b1;
                    end
                end
            end
            ST_SLOT: begin
                // Delay slot runs first; its hazards are not covered
                if (slot_done_in) begin
                    nxt_ff.pc_ld = 1'b1;
                    if (compressed_isa_present_in) begin
                        nxt_ff.pc      = {cur_ff.jtarget[31:1], 1'b0};
                        nxt_ff.isa_sel = cur_ff.jtarget[0];
                    end else begin
                        nxt_ff.pc = cur_ff.jtarget;
                    end
                    nxt_ff.target_misalign = target_fault(cur_ff.jtarget, compressed_isa_present_in);
                    nxt_ff.ehz  = cur_ff.jbarrier | execution_barrier_in;
                    nxt_ff.ihz  = cur_ff.jbarrier;
                    nxt_ff.st   = ST_IDLE;
                    nxt_ff.busy = 1'b0;
                end
            end
            ST_XLATE: begin
                if (xlate_done_in) begin
                    nxt_ff.xreq = 1'b0;
                    nxt_ff.st   = ST_IDLE;
                    nxt_ff.busy = 1'b0;
                    nxt_ff.exc_v = 1'b1;
                    // Exception priority: refill, invalid, address, watch
                    if (xlate_refill_in) begin
                        nxt_ff.exc_c = EXC_TLB_REFIL;
                    end else if (xlate_invalid_in) begin
                        nxt_ff.exc_c = EXC_TLB_INVAL;
                    end else if (xlate_addr_err_in ||
                                 (cur_ff.user_sp && xlate_seg_mode_in != SEG_MAPPED_USER_KERNEL_SEGMENT_MODE &&
                                  xlate_seg_mode_in != SEG_UNMAPPED_USER_SEGMENT_MODE && xlate_seg_mode_in != SEG_MAPPED_USER_SUPER_KERNEL_MODE)) begin
                        nxt_ff.exc_c = EXC_ADDR;
                    end else if (xlate_watch_in) begin
                        nxt_ff.exc_c = EXC_WATCH;
                    end else begin
                        nxt_ff.exc_v = 1'b0;
                        nxt_ff.paddr = {xlate_paddr_in[31:2],
                                        xlate_paddr_in[1:0] ^ {2{reverse_byte_order_flag_in}}};
                        nxt_ff.mreq  = 1'b1;
                        nxt_ff.st    = ST_MEM;
                        nxt_ff.busy  = 1'b1;
                    end
                end
            end
            ST_MEM: begin
                if (mem_done_in) begin
                    nxt_ff.mreq = 1'b0;
                    nxt_ff.st   = ST_IDLE;
                    nxt_ff.busy = 1'b0;
                    // Bus errors exist only for the user space forms
                    if (mem_bus_err_in && cur_ff.user_sp) begin
                        nxt_ff.exc_v = 1'b1;
                        nxt_ff.exc_c = EXC_BUS;
                    end else begin
                        nxt_ff.wb_v = 1'b1;
                        nxt_ff.wb_r = cur_ff.tgt;
                        nxt_ff.wb_d = lane_value;
                    end
                end
            end
        endcase
    end

    // State register, synchronous reset
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            cur_ff         <= '0;
            cur_ff.st      <= ST_IDLE;
            cur_ff.pc      <= RST_PC;
            cur_ff.isa_sel <= RST_ISA_SEL;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Outputs straight from flops
    assign busy_out                   = cur_ff.busy;
    assign xlate_req_out              = cur_ff.xreq;
    assign xlate_vaddr_out            = cur_ff.vaddr;
    assign xlate_user_map_out         = cur_ff.xuser;
    assign mem_req_out                = cur_ff.mreq;
    assign mem_paddr_out              = cur_ff.paddr;
    assign wb_valid_out               = cur_ff.wb_v;
    assign wb_reg_out                 = cur_ff.wb_r;
    assign wb_data_out                = cur_ff.wb_d;
    assign pc_load_out                = cur_ff.pc_ld;
    assign pc_out                     = cur_ff.pc;
    assign instruction_set_select_out = cur_ff.isa_sel;
    assign exec_hazard_clear_out      = cur_ff.ehz;
    assign instr_hazard_clear_out     = cur_ff.ihz;
    assign exc_valid_out              = cur_ff.exc_v;
    assign exc_code_out               = cur_ff.exc_c;

    // Checks
    property p_barrier_clear;
        @(posedge core_clk_in) disable iff (srst_in)
        (cur_ff.st == ST_SLOT && slot_done_in && cur_ff.jbarrier) |=> (instr_hazard_clear_out && pc_load_out);
    endproperty
    a_barrier_clear: assert property (p_barrier_clear) else $error("barrier did not clear hazards");
    property p_ihz_only_jump;
        @(posedge core_clk_in) disable iff (srst_in)
        instr_hazard_clear_out |-> pc_load_out;
    endproperty
    a_ihz_only_jump: assert property (p_ihz_only_jump) else $error("instruction hazard cleared without jump");
    property p_ca_pc;
        @(posedge core_clk_in) disable iff (srst_in)
        (pc_load_out && compressed_isa_present_in) |-> (pc_out[0] == 1'b0);
    endproperty
    a_ca_pc: assert property (p_ca_pc) else $error("pc bit0 not cleared");
    property p_no_jump_exc;
        @(posedge core_clk_in) disable iff (srst_in)
        (cur_ff.st == ST_SLOT) |=> !exc_valid_out || $past(fetch_target_in);
    endproperty
    a_no_jump_exc: assert property (p_no_jump_exc) else $error("jump raised exception");
    property p_slot_first;
        @(posedge core_clk_in) disable iff (srst_in)
        (cur_ff.st == ST_SLOT && !slot_done_in) |=> !pc_load_out;
    endproperty
    a_slot_first: assert property (p_slot_first) else $error("transfer before delay slot");
    property p_phys_xor;
        @(posedge core_clk_in) disable iff (srst_in)
        (cur_ff.st == ST_XLATE && xlate_done_in && nxt_ff.st == ST_MEM) |=>
            mem_paddr_out[1:0] == ($past(xlate_paddr_in[1:0]) ^ {2{$past(reverse_byte_order_flag_in)}});
    endproperty
    a_phys_xor: assert property (p_phys_xor) else $error("physical low bits wrong");
    property p_eva_absent;
        @(posedge core_clk_in) disable iff (srst_in)
        (cur_ff.st == ST_IDLE && instr_valid_in && (dec_lbe || dec_load_unsigned_byte_user_space) && !extended_virtual_addressing_present_in)
            |=> (exc_valid_out && exc_code_out == EXC_RESV_INS && cur_ff.st == ST_IDLE);
    endproperty
    a_eva_absent: assert property (p_eva_absent) else $error("user load ran without feature");
    property p_unsigned_zero;
        @(posedge core_clk_in) disable iff (srst_in)
        (cur_ff.st == ST_MEM && mem_done_in && !cur_ff.is_signed && !(mem_bus_err_in && cur_ff.user_sp))
            |=> (wb_valid_out && wb_data_out[31:8] == 24'h00_0000);
    endproperty
    a_unsigned_zero: assert property (p_unsigned_zero) else $error("unsigned load not zero extended");
    property p_signed_ext;
        @(posedge core_clk_in) disable iff (srst_in)
        (wb_valid_out && $past(cur_ff.is_signed)) |-> (wb_data_out[31:8] == {24{wb_data_out[7]}});
    endproperty
    a_signed_ext: assert property (p_signed_ext) else $error("signed load not sign extended");
    c_jump: cover property (@(posedge core_clk_in) disable iff (srst_in) pc_load_out && instr_hazard_clear_out);
    c_load: cover property (@(posedge core_clk_in) disable iff (srst_in) wb_valid_out);
    c_fault: cover property (@(posedge core_clk_in) disable iff (srst_in) exc_valid_out && exc_code_out == EXC_ADDR);
endmodule

// File: rtl/hjb_pkg.sv
// Package for the barrier jump and byte load execution block.
// Assumes a 32-bit core; shared by the decoder and the byte lane unit.
package hjb_pkg;
    localparam int          WORD_W        = 32;
    // Primary opcodes, bits 31..26
    localparam logic [5:0]  OP_REGULAR    = 6'h00;
    localparam logic [5:0]  OP_EXT_GROUP  = 6'h1F;
    localparam logic [5:0]  OP_LD_SBYTE   = 6'h20;
    localparam logic [5:0]  OP_LD_UBYTE   = 6'h24;
    // Function codes, bits 5..0
    localparam logic [5:0]  FN_JUMP_REG   = 6'h08;
    localparam logic [5:0]  FN_LD_SBYTE_U = 6'h2C;
    localparam logic [5:0]  FN_LD_UBYTE_U = 6'h28;
    // Field positions
    localparam int          POS_OP        = 26;
    localparam int          POS_SRC       = 21;
    localparam int          POS_TGT       = 16;
    localparam int          POS_BARRIER   = 10;
    localparam int          POS_OFF9      = 7;
    // Segment access modes for user space loads
    localparam logic [2:0]  SEG_MAPPED_USER_KERNEL_SEGMENT_MODE     = 3'h1;
    localparam logic [2:0]  SEG_UNMAPPED_USER_SEGMENT_MODE      = 3'h2;
    localparam logic [2:0]  SEG_MAPPED_USER_SUPER_KERNEL_MODE      = 3'h3;
    // Exception cause codes reported by this block
    localparam logic [3:0]  EXC_NONE      = 4'h0;
    localparam logic [3:0]  EXC_ADDR      = 4'h1;
    localparam logic [3:0]  EXC_TLB_REFIL = 4'h2;
    localparam logic [3:0]  EXC_TLB_INVAL = 4'h3;
    localparam logic [3:0]  EXC_BUS       = 4'h4;
    localparam logic [3:0]  EXC_WATCH     = 4'h5;
    localparam logic [3:0]  EXC_RESV_INS  = 4'h6;
    localparam logic [3:0]  EXC_COP_UNUSE = 4'h7;
    // Reset values
    localparam logic [31:0] RST_PC        = 32'hBFC0_0000;
    localparam logic        RST_ISA_SEL   = 1'b0;
    typedef enum logic [1:0] {ST_IDLE, ST_SLOT, ST_XLATE, ST_MEM} hjb_state_type;
endpackage

// File: rtl/hjb_lane_extract.sv
// Byte lane select and extension for byte loads.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
module hjb_lane_extract (
    input  wire logic [31:0] word_in,
    input  wire logic [1:0]  vaddr_lo_in,
    input  wire logic        big_order_cpu_flag_in,
    input  wire logic        signed_in,
    output logic      [31:0] value_out
);
    import hjb_pkg::*;
    logic [1:0] lane;
    logic [7:0] byte_val;
    // Lane from low address bits, flipped for big order
    always_comb begin
        lane      = vaddr_lo_in ^ {2{big_order_cpu_flag_in}};
        byte_val  = word_in[8*lane +: 8];
        value_out = signed_in ? {{24{byte_val[7]}}, byte_val}
                              : {24'h00_0000, byte_val};
    end
endmodule

// File: tb/hjb_mem_model.sv
// Translation and memory stand-in facing the execution unit.
// Assumes requests are levels held until the matching done pulse.
`timescale 1ns/1ps
module hjb_mem_model #(
    parameter logic [31:0] PA_XOR   = 32'h0040_0000,
    parameter logic [31:0] MEM_WORD = 32'h847F_C215
) (
    input  wire logic        clk_in,
    input  wire logic        xlate_req_in,
    input  wire logic [31:0] xlate_vaddr_in,
    input  wire logic        mem_req_in,
    input  wire logic        slow_in,
    input  wire logic [2:0]  seg_mode_in,
    input  wire logic [4:0]  fault_in,
    output logic             xlate_done_out,
    output logic [31:0]      paddr_out,
    output logic [2:0]       seg_out,
    output logic [3:0]       flags_out,
    output logic             mem_done_out,
    output logic [31:0]      word_out,
    output logic             bus_err_out
);
    // Done lines settle low on the first edge, while the unit is still held in reset
    logic [1:0] wait_cnt = 2'h0;
    // Slow mode answers a translation after three waits, a word fetch after two; lines outside a reply carry inverted junk
    always @(posedge clk_in) begin
        wait_cnt <= (xlate_req_in || mem_req_in) ? wait_cnt + 2'h1 : 2'h0;
        xlate_done_out <= 1'h0;
        mem_done_out <= 1'h0;
        paddr_out <= ~paddr_out;
        seg_out <= ~seg_out;
        flags_out <= ~flags_out;
        word_out <= ~word_out;
        bus_err_out <= ~bus_err_out;
        if ((!slow_in || wait_cnt == 2'h3) && !xlate_done_out && !mem_done_out) begin
            if (xlate_req_in) begin
                xlate_done_out <= 1'h1;
                paddr_out <= xlate_vaddr_in ^ PA_XOR;
                seg_out <= seg_mode_in;
                flags_out <= fault_in[4:1];
                wait_cnt <= 2'h0;
            end else if (mem_req_in) begin
                mem_done_out <= 1'h1;
                word_out <= MEM_WORD;
                bus_err_out <= fault_in[0];
                wait_cnt <= 2'h0;
            end
        end
    end
endmodule

// File: tb/test_hazard_jump_and_byte_loads.sv
// Self-checking bench for the barrier jump and byte load unit.
// Assumes the memory model answers translation and word fetches.
`timescale 1ns/1ps
module test_hazard_jump_and_byte_loads;
    import hjb_pkg::*;
    localparam logic [31:0] PA_XOR   = 32'h0040_0000;
    localparam logic [31:0] MEM_WORD = 32'h847F_C215;
    localparam logic [10:0] FTAB [7] = '{{2'h0, 5'h10, EXC_TLB_REFIL}, {2'h1, 5'h08, EXC_TLB_INVAL},
        {2'h0, 5'h04, EXC_ADDR}, {2'h1, 5'h02, EXC_WATCH}, {2'h2, 5'h01, EXC_BUS},
        {2'h0, 5'h01, EXC_NONE}, {2'h3, 5'h18, EXC_TLB_REFIL}};
    logic        core_clk_in = 1'h0;
    logic        srst_in = 1'h1;
    logic        instr_valid_in = 1'h0;
    logic [31:0] instr_in = 32'h0;
    logic [31:0] src_reg_val_in = 32'h0;
    logic        slot_done_in = 1'h0, exb = 1'h0, ca = 1'h0, eva = 1'h1, acc = 1'h1, kern = 1'h1;
    logic        big = 1'h0, rev = 1'h0, fetch = 1'h0, slow = 1'h0;
    logic [2:0]  seg_sel = SEG_MAPPED_USER_KERNEL_SEGMENT_MODE;
    logic [4:0]  fault = 5'h0;
    logic        xdone, mdone, berr, busy, xreq, umap, mreq, wbv, pcl, isa, ehz, ihz, excv;
    logic [31:0] xpa, mword, xva, mpa, wbd, pc;
    logic [2:0]  seg;
    logic [3:0]  xfl, exc;
    logic [4:0]  wbr;
    int          failures = 0;
    int          checks = 0;
    int          cycles = 0;

    hjb_exec u_dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .src_reg_val_in(src_reg_val_in), .slot_done_in(slot_done_in),
        .execution_barrier_in(exb), .compressed_isa_present_in(ca), .extended_virtual_addressing_present_in(eva),
        .control_access_en_in(acc), .kernel_mode_in(kern), .big_order_cpu_flag_in(big),
        .reverse_byte_order_flag_in(rev), .xlate_done_in(xdone), .xlate_paddr_in(xpa), .xlate_seg_mode_in(seg),
        .xlate_refill_in(xfl[3]), .xlate_invalid_in(xfl[2]), .xlate_addr_err_in(xfl[1]), .xlate_watch_in(xfl[0]),
        .mem_done_in(mdone), .mem_word_in(mword), .mem_bus_err_in(berr), .fetch_target_in(fetch),
        .busy_out(busy), .xlate_req_out(xreq), .xlate_vaddr_out(xva), .xlate_user_map_out(umap),
        .mem_req_out(mreq), .mem_paddr_out(mpa), .wb_valid_out(wbv), .wb_reg_out(wbr), .wb_data_out(wbd),
        .pc_load_out(pcl), .pc_out(pc), .instruction_set_select_out(isa), .exec_hazard_clear_out(ehz),
        .instr_hazard_clear_out(ihz), .exc_valid_out(excv), .exc_code_out(exc));

    hjb_mem_model #(.PA_XOR(PA_XOR), .MEM_WORD(MEM_WORD)) u_mem (.clk_in(core_clk_in), .xlate_req_in(xreq),
        .xlate_vaddr_in(xva), .mem_req_in(mreq), .slow_in(slow), .seg_mode_in(seg_sel), .fault_in(fault),
        .xlate_done_out(xdone), .paddr_out(xpa), .seg_out(seg), .flags_out(xfl), .mem_done_out(mdone),
        .word_out(mword), .bus_err_out(berr));

    // 40 MHz clock and a cycle ceiling far above the few hundred cycles needed
    always #12.5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Issue waits for idle first, since a word offered while busy is dropped
    task automatic issue(input logic [31:0] ins, input logic [31:0] src);
        for (int i = 0; i < 30 && busy !== 1'h0; i++) @(negedge core_clk_in);
        instr_in = ins;
        src_reg_val_in = src;
        instr_valid_in = 1'h1;
        @(negedge core_clk_in);
        instr_valid_in = 1'h0;
    endtask

    // Kind bit 1 picks the user space form, bit 0 the unsigned form
    task automatic ld(input logic [1:0] kind, input logic [15:0] off, input logic [31:0] base,
                      input logic [4:0] rt, input logic [3:0] ex);
        logic [31:0] va;
        logic [7:0]  b;
        logic [31:0] want;
        va = base + (kind[1] ? {{23{off[8]}}, off[8:0]} : {{16{off[15]}}, off});
        b = 8'(MEM_WORD >> (8 * (va[1:0] ^ {2{big}})));
        want = kind[0] ? {24'h0, b} : {{24{b[7]}}, b};
        issue(kind[1] ? {OP_EXT_GROUP, 5'h3, rt, off[8:0], 1'h0, kind[0] ? FN_LD_UBYTE_U : FN_LD_SBYTE_U}
                      : {kind[0] ? OP_LD_UBYTE : OP_LD_SBYTE, 5'h3, rt, off}, base);
        for (int i = 0; i < 30 && wbv !== 1'h1 && excv !== 1'h1; i++) begin
            if (xreq === 1'h1) cmp(xva, va, "vaddr");
            if (xreq === 1'h1) cmp(umap, kind[1] & kern, "user map");
            if (mreq === 1'h1) cmp(mpa, (va ^ PA_XOR) ^ {30'h0, {2{rev}}}, "paddr");
            @(negedge core_clk_in);
        end
        cmp(excv, ex !== EXC_NONE, "exc valid");
        if (ex !== EXC_NONE) cmp(exc, ex, "exc code");
        if (ex === EXC_NONE) cmp(wbr, rt, "wb reg");
        if (ex === EXC_NONE) cmp(wbd, want, "wb data");
    endtask

    task automatic jmp(input logic c, input logic hb, input logic [31:0] src, input logic [3:0] ex);
        ca = c;
        issue({OP_REGULAR, 5'h9, 10'h0, hb, 4'h0, FN_JUMP_REG}, src);
        repeat (2) begin
            cmp({pcl, ihz, busy}, 3'h1, "early transfer");
            @(negedge core_clk_in);
        end
        slot_done_in = 1'h1;
        @(negedge core_clk_in);
        slot_done_in = 1'h0;
        for (int i = 0; i < 4 && pcl !== 1'h1; i++) @(negedge core_clk_in);
        cmp(pc, c ? {src[31:1], 1'h0} : src, "target");
        if (c) cmp(isa, src[0], "isa select");
        cmp({ihz, ehz}, {2{hb}}, "hazard clears");
        cmp(excv, 1'h0, "jump exc");
        @(negedge core_clk_in);
        fetch = 1'h1;
        @(negedge core_clk_in);
        fetch = 1'h0;
        for (int i = 0; i < 3 && excv !== 1'h1; i++) @(negedge core_clk_in);
        cmp(excv, ex !== EXC_NONE, "fetch fault");
        if (ex !== EXC_NONE) cmp(exc, ex, "fetch code");
    endtask

    initial begin
        repeat (2) @(posedge core_clk_in);
        @(negedge core_clk_in);
        srst_in = 1'h0;
        cmp({busy, isa, pcl, excv, pc}, {4'h0, RST_PC}, "reset state");
        // Every lane, both orders, both extensions, prompt and slow answers
        for (int k = 0; k < 32; k++) begin
            big = k[2];
            rev = k[3];
            slow = k[0];
            ld({1'h0, k[4]}, 16'hFFF0 + 16'(k[1:0]), 32'h0000_2003, 5'(8 + k), EXC_NONE);
        end
        $display("test plain loads done");
        for (int k = 0; k < 6; k++) begin
            seg_sel = 3'(k % 3 + 1);
            kern = (k != 5);
            ld({1'h1, k[0]}, 16'h01FD, 32'h8000_1000 + 32'(k), 5'h5, EXC_NONE);
        end
        kern = 1'h1;
        $display("test user loads done");
        for (int k = 0; k < 7; k++) begin
            fault = FTAB[k][8:4];
            ld(FTAB[k][10:9], 16'h0005, 32'h0000_3000, 5'h6, FTAB[k][3:0]);
        end
        fault = 5'h0;
        eva = 1'h0;
        ld(2'h2, 16'h0, 32'h100, 5'h4, EXC_RESV_INS);
        eva = 1'h1;
        acc = 1'h0;
        ld(2'h3, 16'h0, 32'h100, 5'h4, EXC_COP_UNUSE);
        acc = 1'h1;
        seg_sel = 3'h0;
        ld(2'h2, 16'h0, 32'h100, 5'h4, EXC_ADDR);
        seg_sel = SEG_MAPPED_USER_KERNEL_SEGMENT_MODE;
        $display("test load faults done");
        kern = 1'h0;
        acc = 1'h0;
        jmp(1'h0, 1'h1, 32'h0000_4000, EXC_NONE);
        kern = 1'h1;
        acc = 1'h1;
        jmp(1'h0, 1'h0, 32'h0000_4002, EXC_ADDR);
        jmp(1'h0, 1'h1, 32'h0000_4001, EXC_ADDR);
        jmp(1'h1, 1'h1, 32'h0000_4003, EXC_NONE);
        jmp(1'h1, 1'h0, 32'h0000_4002, EXC_ADDR);
        jmp(1'h1, 1'h1, 32'h0000_4000, EXC_NONE);
        $display("test jumps done");
        exb = 1'h1;
        @(negedge core_clk_in);
        exb = 1'h0;
        for (int i = 0; i < 2 && ehz !== 1'h1; i++) @(negedge core_clk_in);
        cmp({ehz, ihz}, 2'h2, "exec barrier");
        $display("test execution barrier done");
        finish_test();
    end
endmodule
